// ==== src/iopa_map.svh ====
`ifndef IOPA_MAP_SVH
`define IOPA_MAP_SVH
// How it works
// - each 4-bit selector decodes to 0..128 points; 0 and B give 128
// - request to main unit equals the decoded input and output counts
// - when request exceeds 128, inputs are granted fully, outputs take the rest
// - with a smaller offer, inputs are served first up to it, outputs the rest
// - slave inputs beyond the selected input count never reach shared memory
// - shared memory outputs beyond the selected output count never reach the network
// - address detection records all connected slave addresses into non-volatile memory
// - parameters refresh after a save and when unassigned or duplicate addresses appear while no fault is recorded
// - saved address list survives power loss; fault records and parameters do not

// ----------------------------------------------------------------
// limits and timing
// ----------------------------------------------------------------
`define IOPA_MAX_POINTS   8'd128
`define IOPA_SETTLE_CYC   4'd3
`endif

// ==== src/iopa_pkg.sv ====
package iopa_pkg;
    typedef struct packed {
        logic [7:0] in_pts;
        logic [7:0] out_pts;
    } iopa_count_type;

    typedef enum logic [4:0] {
        IOPA_SAMPLE = 5'b00001,
        IOPA_REQ    = 5'b00010,
        IOPA_RUN    = 5'b00100,
        IOPA_SAVE   = 5'b01000,
        IOPA_REFR   = 5'b10000
    } iopa_state_type;
endpackage

// ==== src/iopa_alloc.sv ====
`timescale 1ns/1ps
`include "iopa_map.svh"
// slave addresses index points 0..127; a slave id is the point index of its first bit
module iopa_alloc #(
    parameter int SLAVES = 128
) (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic [3:0]                  sel_in_pin,
    input  wire logic [3:0]                  sel_out_pin,
    output iopa_pkg::iopa_count_type         req_reg,
    output logic                             req_valid_reg,
    input  wire logic [7:0]                  offer,
    output iopa_pkg::iopa_count_type         grant_reg,
    input  wire logic                        net_in_valid,
    input  wire logic [6:0]                  net_in_addr,
    input  wire logic                        net_in_bit,
    output logic                             shm_wr_reg,
    output logic [6:0]                       shm_wr_addr_reg,
    output logic                             shm_wr_bit_reg,
    input  wire logic                        shm_out_valid,
    input  wire logic [6:0]                  shm_out_addr,
    input  wire logic                        shm_out_bit,
    output logic                             net_out_valid_reg,
    output logic [6:0]                       net_out_addr_reg,
    output logic                             net_out_bit_reg,
    input  wire logic                        detect_start,
    input  wire logic [SLAVES-1:0]           slave_present,
    input  wire logic [SLAVES-1:0]           slave_unset,
    input  wire logic [SLAVES-1:0]           slave_dup,
    output logic                             nv_wr_reg,
    output logic [SLAVES-1:0]                nv_data_reg,
    output logic                             param_refresh_reg,
    output logic [SLAVES-1:0]                fault_unset_reg,
    output logic [SLAVES-1:0]                fault_dup_reg,
    output logic                             busy_reg
);
    // ----------------------------------------------------------------
    // selector decode
    // ----------------------------------------------------------------
    function automatic logic [7:0] iopa_decode(input logic [3:0] sw);
        case (sw)
            4'h0, 4'hb: iopa_decode = `IOPA_MAX_POINTS;
            4'h2:       iopa_decode = 8'h08;
            4'h3:       iopa_decode = 8'h10;
            4'h4:       iopa_decode = 8'h18;
            4'h5:       iopa_decode = 8'h20;
            4'h6:       iopa_decode = 8'h30;
            4'h7:       iopa_decode = 8'h40;
            4'h8:       iopa_decode = 8'h50;
            4'h9:       iopa_decode = 8'h60;
            4'ha:       iopa_decode = 8'h70;
            default:    iopa_decode = 8'h00; // 1 and c..f
        endcase
    endfunction

    function automatic logic [7:0] iopa_min(input logic [7:0] a, input logic [7:0] b);
        iopa_min = (a < b) ? a : b;
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] sin_meta_reg, sin_reg, sout_meta_reg, sout_reg;
    // first stage read only by second stage
    always_ff @(posedge clk) begin
        sin_meta_reg  <= sel_in_pin;
        sin_reg       <= sin_meta_reg;
        sout_meta_reg <= sel_out_pin;
        sout_reg      <= sout_meta_reg;
    end

    // ----------------------------------------------------------------
    // control sequence
    // ----------------------------------------------------------------
    iopa_pkg::iopa_state_type state_reg;
    logic [3:0]               settle_reg;
    logic [7:0]               cap;
    logic [7:0]               in_g;
    logic [8:0]               rest;

    // offer clipped to the ceiling even if the main unit misbehaves
    assign cap  = iopa_min(offer, `IOPA_MAX_POINTS);
    assign in_g = iopa_min(req_reg.in_pts, cap);
    assign rest = {1'b0, cap} - {1'b0, in_g};

    // settle counter lets the synchronisers fill before sampling
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg      <= iopa_pkg::IOPA_SAMPLE;
            settle_reg     <= 4'h0;
            req_reg        <= '0;
            req_valid_reg  <= 1'b0;
            grant_reg      <= '0;
        end else begin
            case (state_reg)
                iopa_pkg::IOPA_SAMPLE: begin
                    settle_reg <= settle_reg + 4'h1;
                    if (settle_reg == `IOPA_SETTLE_CYC) begin
                        req_reg.in_pts  <= iopa_decode(sin_reg);
                        req_reg.out_pts <= iopa_decode(sout_reg);
                        req_valid_reg   <= 1'b1;
                        state_reg       <= iopa_pkg::IOPA_REQ;
                    end
                end
                iopa_pkg::IOPA_REQ: begin
                    grant_reg.in_pts  <= in_g;
                    grant_reg.out_pts <= iopa_min(req_reg.out_pts, rest[7:0]);
                    state_reg         <= iopa_pkg::IOPA_RUN;
                end
                iopa_pkg::IOPA_RUN: begin
                    if (detect_start)
                        state_reg <= iopa_pkg::IOPA_SAVE;
                end
                iopa_pkg::IOPA_SAVE: state_reg <= iopa_pkg::IOPA_REFR;
                iopa_pkg::IOPA_REFR: state_reg <= iopa_pkg::IOPA_RUN;
                default:             state_reg <= iopa_pkg::IOPA_SAMPLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // data masking; selector counts, not grants, bound the traffic
    // ----------------------------------------------------------------
    logic live;
    assign live = (state_reg == iopa_pkg::IOPA_RUN) || (state_reg == iopa_pkg::IOPA_SAVE)
                  || (state_reg == iopa_pkg::IOPA_REFR);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shm_wr_reg        <= 1'b0;
            shm_wr_addr_reg   <= 7'h00;
            shm_wr_bit_reg    <= 1'b0;
            net_out_valid_reg <= 1'b0;
            net_out_addr_reg  <= 7'h00;
            net_out_bit_reg   <= 1'b0;
        end else begin
            shm_wr_reg        <= live && net_in_valid && ({1'b0, net_in_addr} < req_reg.in_pts);
            shm_wr_addr_reg   <= net_in_addr;
            shm_wr_bit_reg    <= net_in_bit;
            net_out_valid_reg <= live && shm_out_valid && ({1'b0, shm_out_addr} < req_reg.out_pts);
            net_out_addr_reg  <= shm_out_addr;
            net_out_bit_reg   <= shm_out_bit;
        end
    end

    // ----------------------------------------------------------------
    // address detection and parameter refresh
    // ----------------------------------------------------------------
    logic any_fault;
    assign any_fault = (|slave_unset) || (|slave_dup);

    // fault records live in plain flops, so power loss clears them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nv_wr_reg         <= 1'b0;
            nv_data_reg       <= '0;
            param_refresh_reg <= 1'b0;
            fault_unset_reg   <= '0;
            fault_dup_reg     <= '0;
            busy_reg          <= 1'b0;
        end else begin
            nv_wr_reg <= (state_reg == iopa_pkg::IOPA_RUN) && detect_start;
            if ((state_reg == iopa_pkg::IOPA_RUN) && detect_start)
                nv_data_reg <= slave_present;
            fault_unset_reg   <= slave_unset;
            fault_dup_reg     <= slave_dup;
            param_refresh_reg <= (state_reg == iopa_pkg::IOPA_SAVE)
                                 || (live && any_fault && !(|fault_unset_reg) && !(|fault_dup_reg));
            busy_reg          <= !live || (state_reg != iopa_pkg::IOPA_RUN);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_grant_ceiling: assert property (@(posedge clk) disable iff (!rst_n)
        ({1'b0, grant_reg.in_pts} + {1'b0, grant_reg.out_pts}) <= {1'b0, `IOPA_MAX_POINTS})
        else $error("grant exceeds ceiling");
    chk_input_first: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == iopa_pkg::IOPA_REQ |=> grant_reg.in_pts == iopa_min(req_reg.in_pts, $past(cap)))
        else $error("inputs not served first");
    chk_output_rest: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == iopa_pkg::IOPA_REQ |=> grant_reg.out_pts
            == iopa_min(req_reg.out_pts, 8'($past(cap) - grant_reg.in_pts)))
        else $error("outputs not given remainder");
    chk_in_mask: assert property (@(posedge clk) disable iff (!rst_n)
        shm_wr_reg |-> ({1'b0, shm_wr_addr_reg} < req_reg.in_pts))
        else $error("masked input reached memory");
    chk_out_mask: assert property (@(posedge clk) disable iff (!rst_n)
        net_out_valid_reg |-> ({1'b0, net_out_addr_reg} < req_reg.out_pts))
        else $error("masked output reached network");
    chk_nv_save: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == iopa_pkg::IOPA_RUN && detect_start) |=> nv_wr_reg && nv_data_reg == $past(slave_present))
        else $error("detection not saved");
    chk_refresh_save: assert property (@(posedge clk) disable iff (!rst_n)
        nv_wr_reg |=> param_refresh_reg)
        else $error("no refresh after save");
    chk_req_hold: assert property (@(posedge clk) disable iff (!rst_n)
        req_valid_reg |=> req_valid_reg && $stable(req_reg))
        else $error("request changed after sampling");
    chk_req_decode: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(req_valid_reg) |-> req_reg.in_pts == iopa_decode($past(sin_reg)))
        else $error("request differs from selector");
    chk_req_decode_out: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(req_valid_reg) |-> req_reg.out_pts == iopa_decode($past(sout_reg)))
        else $error("output request differs from selector");
    chk_decode_step: assert property (@(posedge clk) disable iff (!rst_n)
        req_valid_reg |-> (req_reg.in_pts <= `IOPA_MAX_POINTS) && (req_reg.in_pts[2:0] == 3'h0)
            && (req_reg.out_pts <= `IOPA_MAX_POINTS) && (req_reg.out_pts[2:0] == 3'h0))
        else $error("request not a legal point count");
    chk_early_drop: assert property (@(posedge clk) disable iff (!rst_n)
        !live |=> !shm_wr_reg && !net_out_valid_reg)
        else $error("traffic passed before running");
    chk_refresh_fault: assert property (@(posedge clk) disable iff (!rst_n)
        (live && ((|slave_unset) || (|slave_dup)) && !(|$past(slave_unset)) && !(|$past(slave_dup)))
            |=> param_refresh_reg)
        else $error("no refresh after new fault");
    chk_fault_clear: assert property (@(posedge clk)
        !rst_n |=> (fault_unset_reg == '0) && (fault_dup_reg == '0) && !nv_wr_reg)
        else $error("fault records kept over reset");
    chk_save_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        nv_wr_reg |=> !nv_wr_reg)
        else $error("save pulse repeated");
endmodule

// ==== bench/iopa_main_unit.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// main unit model: offers points to the master
// ----------------------------------------------------------------
module iopa_main_unit (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] room,
    output logic [7:0]      offer
);
    // offer never tops the total ceiling; split between in and out is left to the master
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            offer <= 8'h80;
        end else begin
            offer <= (room > 8'h80) ? 8'h80 : room;
        end
    end
endmodule

// ==== bench/iopa_alloc_test.sv ====
`timescale 1ns/1ps
module iopa_alloc_test;
    logic clk, rst_n, net_in_valid, net_in_bit, shm_out_valid, shm_out_bit, detect_start;
    logic [3:0]   sel_in_pin, sel_out_pin;
    logic [7:0]   offer, room;
    logic [6:0]   net_in_addr, shm_out_addr, shm_wr_addr_reg, net_out_addr_reg;
    logic [127:0] slave_present, slave_unset, slave_dup, nv_data_reg, fault_unset_reg, fault_dup_reg;
    logic         req_valid_reg, shm_wr_reg, shm_wr_bit_reg, net_out_valid_reg, net_out_bit_reg;
    logic         nv_wr_reg, param_refresh_reg, busy_reg;
    iopa_pkg::iopa_count_type req_reg, grant_reg;
    int error_cnt, check_count, n;
    iopa_main_unit MU (.clk(clk), .rst_n(rst_n), .room(room), .offer(offer));
    iopa_alloc DUT (.clk(clk), .rst_n(rst_n), .sel_in_pin(sel_in_pin), .sel_out_pin(sel_out_pin),
        .req_reg(req_reg), .req_valid_reg(req_valid_reg), .offer(offer), .grant_reg(grant_reg),
        .net_in_valid(net_in_valid), .net_in_addr(net_in_addr), .net_in_bit(net_in_bit),
        .shm_wr_reg(shm_wr_reg), .shm_wr_addr_reg(shm_wr_addr_reg), .shm_wr_bit_reg(shm_wr_bit_reg),
        .shm_out_valid(shm_out_valid), .shm_out_addr(shm_out_addr), .shm_out_bit(shm_out_bit),
        .net_out_valid_reg(net_out_valid_reg), .net_out_addr_reg(net_out_addr_reg),
        .net_out_bit_reg(net_out_bit_reg), .detect_start(detect_start), .slave_present(slave_present),
        .slave_unset(slave_unset), .slave_dup(slave_dup), .nv_wr_reg(nv_wr_reg), .nv_data_reg(nv_data_reg),
        .param_refresh_reg(param_refresh_reg), .fault_unset_reg(fault_unset_reg),
        .fault_dup_reg(fault_dup_reg), .busy_reg(busy_reg));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(string what, logic [127:0] seen, logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // point count of one selector code, worked out independently of the design
    function automatic logic [7:0] dec(logic [3:0] v);
        case (v)
            4'h0, 4'hb: return 8'h80;
            4'h2, 4'h3, 4'h4, 4'h5: return 8'h08 * (v - 4'h1);
            4'h6, 4'h7, 4'h8, 4'h9, 4'ha: return 8'h10 * (v - 4'h3);
            default: return 8'h00;
        endcase
    endfunction
    // inputs served first, outputs take what is left of the offer
    function automatic logic [15:0] gr(logic [7:0] i, logic [7:0] o, logic [7:0] c);
        logic [7:0] gi;
        gi = (i < c) ? i : c;
        return {gi, (o < c - gi) ? o : c - gi};
    endfunction
    // selectors are only read after a reset, so every setting needs its own boot
    task automatic boot(logic [3:0] si, logic [3:0] so, logic [7:0] rm);
        rst_n = 1'b0;
        sel_in_pin = si;
        sel_out_pin = so;
        room = rm;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        for (n = 0; n < 20 && req_valid_reg !== 1'b1; n++) @(negedge clk);
        if (n == 20) begin
            error_cnt++;
            end_sim();
        end
        @(negedge clk);
    endtask
    task automatic t_decode();
        for (int v = 0; v < 16; v++) begin
            boot(v[3:0], 4'hf - v[3:0], 8'h80);
            check("req", req_reg, {dec(v[3:0]), dec(4'hf - v[3:0])});
            check("valid", req_valid_reg, 1'b1);
            check("grant", grant_reg, gr(dec(v[3:0]), dec(4'hf - v[3:0]), 8'h80));
        end
        boot(4'h9, 4'h7, 8'h80);
        check("grant 96/32", grant_reg, 16'h6020);
        boot(4'h7, 4'h7, 8'h30);
        check("grant 48/0", grant_reg, 16'h3000);
        $display("test decode done");
    endtask
    // one idle cycle after each event, so the next call never raises valid in the step it fell
    task automatic ev(logic o, logic [6:0] a, logic hit);
        if (o) {shm_out_valid, shm_out_addr, shm_out_bit} = {1'b1, a, a[3]};
        else {net_in_valid, net_in_addr, net_in_bit} = {1'b1, a, a[3]};
        @(negedge clk);
        {shm_out_valid, net_in_valid} = 2'b00;
        check("pass", o ? net_out_valid_reg : shm_wr_reg, hit);
        if (hit) check("addr", o ? net_out_addr_reg : shm_wr_addr_reg, a);
        if (hit) check("bit", o ? net_out_bit_reg : shm_wr_bit_reg, a[3]);
        @(negedge clk);
    endtask
    task automatic t_mask();
        boot(4'h2, 4'h3, 8'h80);
        ev(1'b0, 7'h07, 1'b1);
        ev(1'b0, 7'h08, 1'b0);
        ev(1'b1, 7'h0f, 1'b1);
        ev(1'b1, 7'h10, 1'b0);
        check("busy idle", busy_reg, 1'b0);
        sel_in_pin = 4'hb;
        repeat (8) @(negedge clk);
        check("req held", req_reg, 16'h0810);
        ev(1'b0, 7'h08, 1'b0);
        $display("test mask done");
    endtask
    task automatic t_detect();
        slave_present = {4{32'h8000_0a05}};
        detect_start = 1'b1;
        @(negedge clk);
        detect_start = 1'b0;
        check("nv_wr", nv_wr_reg, 1'b1);
        check("nv_data", nv_data_reg, {4{32'h8000_0a05}});
        @(negedge clk);
        check("refresh", param_refresh_reg, 1'b1);
        check("busy detect", busy_reg, 1'b1);
        repeat (3) @(negedge clk);
        slave_dup = 128'h10;
        for (n = 0; n < 4 && param_refresh_reg !== 1'b1; n++) @(negedge clk);
        check("dup refresh", param_refresh_reg, 1'b1);
        check("dup rec", fault_dup_reg, 128'h10);
        slave_dup = 128'h0;
        @(negedge clk);
        slave_unset = 128'h20;
        for (n = 0; n < 4 && param_refresh_reg !== 1'b1; n++) @(negedge clk);
        check("unset refresh", param_refresh_reg, 1'b1);
        check("unset rec", fault_unset_reg, 128'h20);
        // faults still present at the pins, so only the reset can clear the records
        rst_n = 1'b0;
        slave_dup = 128'h10;
        @(negedge clk);
        check("unset lost", fault_unset_reg, 128'h0);
        check("dup lost rst", fault_dup_reg, 128'h0);
        {slave_unset, slave_dup} = 0;
        boot(4'h2, 4'h3, 8'h80);
        check("dup lost", fault_dup_reg, 128'h0);
        $display("test detect done");
    endtask
    initial begin
        {error_cnt, check_count} = 0;
        {rst_n, net_in_valid, net_in_bit, shm_out_valid, shm_out_bit, detect_start} = 0;
        {sel_in_pin, sel_out_pin, room, net_in_addr, shm_out_addr} = 0;
        {slave_present, slave_unset, slave_dup} = 0;
        t_decode();
        t_mask();
        t_detect();
        end_sim();
    end
endmodule
